//--- pkg/peripheral_irq_cfg.svh
// constants for the peripheral interrupt logic
// assumes inclusion by bare name from the package and the design file
`ifndef PERIPHERAL_IRQ_CFG_SVH
`define PERIPHERAL_IRQ_CFG_SVH
`define SRC_COUNT 4
`define SRC_EEPROM 0
`define SRC_TOUCH 1
`define SRC_SERIAL 2
`define SRC_ADC 3
`define VEC_WIDTH 12
`define VEC_EEPROM 12'h01c
`define VEC_TOUCH 12'h008
`define VEC_SERIAL 12'h018
`define VEC_ADC 12'h020
`define STACK_DEPTH 8
`define ADDR_CTRL 4'h0
`define ADDR_FLAGS 4'h1
`define ADDR_STACK 4'h2
`define BIT_GIE 4
`define BIT_CFOV 4
`define BIT_M0OV 5
`endif

//--- pkg/peripheral_irq_pkg.sv
// types for the peripheral interrupt logic
// assumes the cfg header sits on the include path
`include "peripheral_irq_cfg.svh"
package peripheral_irq_pkg;
  typedef struct packed {
    logic eeprom_write_done;
    logic touch_slot_overflow;
    logic touch_cap_freq_overflow;
    logic touch_module0_overflow;
    logic serial_byte_done;
    logic serial_addr_match;
    logic serial_timeout;
    logic adc_done;
  } periph_events_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  typedef struct packed {
    logic vector_valid;
    logic [`VEC_WIDTH-1:0] vector_addr;
  } vector_out_type;
  typedef enum logic [1:0] {ST_RUN, ST_VECTOR} seq_state_type;
endpackage

//--- hw/peripheral_interrupt_logic.sv
// request flags, enables, vectoring and wake-up for four peripheral sources
// assumes the sequencer pulses stack_pop/exit strobes and accepts vectors immediately
//
// Contract
// - eeprom write end sets its flag
// - vector needs flag, enable, global enable, stack room
// - eeprom service clears flag and global enable
// - touch slot overflow sets touch flag
// - touch service clears flag and global enable
// - any c/f counter overflow sets sticky flag
// - module0 counter overflow sets sticky flag
// - serial byte, match or timeout sets flag
// - serial service clears flag and global enable
// - adc conversion end sets adc flag
// - adc service clears flag and global enable
// - rising request flag produces wake-up
// - wake-up ignores all enable bits
// - flag holds until serviced or cleared
// - only program counter pushed on vector
// - interrupt exit restores pc, sets global enable
// - plain exit keeps global enable low
// - each source owns a distinct vector
// - global enable low blocks all service
//
// Chosen here: the register offsets and the strobed register port.
`include "peripheral_irq_cfg.svh"
module peripheral_interrupt_logic #(
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire peripheral_irq_pkg::periph_events_type events_in,
  input wire peripheral_irq_pkg::reg_req_type bus_in,
  input wire logic [3:0] stack_level_in,
  input wire logic irq_exit_instr_in,
  input wire logic plain_subroutine_exit_in,
  output logic [7:0] rdata_out,
  output peripheral_irq_pkg::vector_out_type vector_out,
  output logic push_pc_out,
  output logic wakeup_out
);
  import peripheral_irq_pkg::*;

  // the level port is four bits wide, so deeper stacks cannot be told apart
  if (STACK_DEPTH < 1 || STACK_DEPTH > 15) begin : g_bad_depth
    $error("stack depth out of range");
  end

  logic [`SRC_COUNT-1:0] flag_reg;
  logic [`SRC_COUNT-1:0] flag_prev_reg;
  logic [`SRC_COUNT-1:0] enable_reg;
  logic global_irq_enable_reg;
  logic touch_cap_freq_overflow_flag_reg;
  logic touch_module0_overflow_flag_reg;
  logic [`SRC_COUNT-1:0] set_ev;
  logic [`SRC_COUNT-1:0] eligible;
  logic [`SRC_COUNT-1:0] grant;
  logic [`SRC_COUNT-1:0] sw_clr;
  logic [`SRC_COUNT-1:0] sw_set;
  logic stack_full;
  logic take;
  logic [`VEC_WIDTH-1:0] vec_sel;
  seq_state_type state_reg;
  logic wr_ctrl;
  logic wr_flags;

  assign wr_ctrl = bus_in.wr && bus_in.addr == `ADDR_CTRL;
  assign wr_flags = bus_in.wr && bus_in.addr == `ADDR_FLAGS;

  // hardware event inputs per source
  assign set_ev[`SRC_EEPROM] = events_in.eeprom_write_done;
  assign set_ev[`SRC_TOUCH] = events_in.touch_slot_overflow;
  assign set_ev[`SRC_SERIAL] = events_in.serial_byte_done | events_in.serial_addr_match
                               | events_in.serial_timeout;
  assign set_ev[`SRC_ADC] = events_in.adc_done;

  assign stack_full = stack_level_in >= 4'(STACK_DEPTH);

  // flags register write replaces bits; writing 1 lets software preset a flag before sleep
  assign sw_set = wr_flags ? bus_in.wdata[`SRC_COUNT-1:0] : '0;
  assign sw_clr = wr_flags ? ~bus_in.wdata[`SRC_COUNT-1:0] : '0;

  // one vector per cycle pair; state blocks a second grant while the first lands
  assign eligible = flag_reg & enable_reg & {`SRC_COUNT{global_irq_enable_reg}};
  assign take = state_reg == ST_RUN && |eligible && !stack_full;

  always_comb begin
    grant = '0;
    vec_sel = `VEC_EEPROM;
    // touch, then serial, then eeprom, then adc
    if (eligible[`SRC_TOUCH]) begin
      grant[`SRC_TOUCH] = 1'b1;
      vec_sel = `VEC_TOUCH;
    end else if (eligible[`SRC_SERIAL]) begin
      grant[`SRC_SERIAL] = 1'b1;
      vec_sel = `VEC_SERIAL;
    end else if (eligible[`SRC_EEPROM]) begin
      grant[`SRC_EEPROM] = 1'b1;
      vec_sel = `VEC_EEPROM;
    end else if (eligible[`SRC_ADC]) begin
      grant[`SRC_ADC] = 1'b1;
      vec_sel = `VEC_ADC;
    end
    if (!take) begin
      grant = '0;
    end
  end

  // set wins over both hardware service clear and software clear
  genvar gi;
  generate
    for (gi = 0; gi < `SRC_COUNT; gi++) begin : g_flag
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          flag_reg[gi] <= 1'b0;
        end else if (set_ev[gi] || sw_set[gi]) begin
          flag_reg[gi] <= 1'b1;
        end else if (grant[gi] || sw_clr[gi]) begin
          flag_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      touch_cap_freq_overflow_flag_reg <= 1'b0;
      touch_module0_overflow_flag_reg <= 1'b0;
    end else begin
      if (events_in.touch_cap_freq_overflow) begin
        touch_cap_freq_overflow_flag_reg <= 1'b1;
      end else if (wr_flags && !bus_in.wdata[`BIT_CFOV]) begin
        touch_cap_freq_overflow_flag_reg <= 1'b0;
      end
      if (events_in.touch_module0_overflow) begin
        touch_module0_overflow_flag_reg <= 1'b1;
      end else if (wr_flags && !bus_in.wdata[`BIT_M0OV]) begin
        touch_module0_overflow_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_reg <= '0;
    end else if (wr_ctrl) begin
      enable_reg <= bus_in.wdata[`SRC_COUNT-1:0];
    end
  end

  // hardware clear on service beats a same-cycle software write
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      global_irq_enable_reg <= 1'b0;
    end else if (take) begin
      global_irq_enable_reg <= 1'b0;
    end else if (irq_exit_instr_in) begin
      global_irq_enable_reg <= 1'b1;
    end else if (wr_ctrl) begin
      global_irq_enable_reg <= bus_in.wdata[`BIT_GIE];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_RUN;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (take) begin
            state_reg <= ST_VECTOR;
          end
        end
        ST_VECTOR: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // only the pc goes on the stack; the sequencer does the push
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      vector_out <= '0;
      push_pc_out <= 1'b0;
    end else begin
      vector_out.vector_valid <= take;
      vector_out.vector_addr <= take ? vec_sel : vector_out.vector_addr;
      push_pc_out <= take;
    end
  end

  // flags are registered here, so the edge detector sees settled state
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_prev_reg <= '0;
      wakeup_out <= 1'b0;
    end else begin
      flag_prev_reg <= flag_reg;
      wakeup_out <= |(flag_reg & ~flag_prev_reg);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        `ADDR_CTRL: rdata_out <= {3'h0, global_irq_enable_reg, enable_reg};
        `ADDR_FLAGS: rdata_out <= {2'h0, touch_module0_overflow_flag_reg,
                                   touch_cap_freq_overflow_flag_reg, flag_reg};
        `ADDR_STACK: rdata_out <= {4'h0, stack_level_in};
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  // plain exit changes nothing here: the global enable simply stays as it is
  logic unused_plain_exit;
  assign unused_plain_exit = plain_subroutine_exit_in;

  // every property samples on the rising clock edge and sleeps through reset
  service_clears_gie_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      take |=> !global_irq_enable_reg)
    else $error("global enable not cleared on service");
  no_vector_gie_low_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      !global_irq_enable_reg |=> !vector_out.vector_valid)
    else $error("vector while disabled");
  no_vector_full_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      stack_full |=> !vector_out.vector_valid)
    else $error("vector with full stack");
  eeprom_flag_set_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      events_in.eeprom_write_done |=> flag_reg[`SRC_EEPROM])
    else $error("eeprom flag missed");
  serial_flag_set_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      events_in.serial_byte_done || events_in.serial_addr_match || events_in.serial_timeout |=> flag_reg[`SRC_SERIAL])
    else $error("serial flag missed");
  adc_flag_set_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      events_in.adc_done |=> flag_reg[`SRC_ADC])
    else $error("adc flag missed");
  touch_flag_set_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      events_in.touch_slot_overflow |=> flag_reg[`SRC_TOUCH])
    else $error("touch flag missed");
  flag_holds_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      flag_reg[`SRC_ADC] && !grant[`SRC_ADC] && !wr_flags |=> flag_reg[`SRC_ADC])
    else $error("adc flag dropped");
  wake_on_rise_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      $rose(flag_reg[`SRC_TOUCH]) |=> wakeup_out)
    else $error("no wake-up on flag rise");
  exit_sets_gie_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      irq_exit_instr_in && !take |=> global_irq_enable_reg)
    else $error("exit did not enable");
  cfov_sticky_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      touch_cap_freq_overflow_flag_reg && !wr_flags |=> touch_cap_freq_overflow_flag_reg)
    else $error("cf overflow flag cleared by hardware");
  m0ov_sticky_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      touch_module0_overflow_flag_reg && !wr_flags |=> touch_module0_overflow_flag_reg)
    else $error("module0 overflow flag cleared by hardware");

  // per-source service and vector properties, then priority, spacing, push, plain-exit and any-flag wake-up properties
  eeprom_flag_clr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_EEPROM] && !events_in.eeprom_write_done && !wr_flags |=> !flag_reg[`SRC_EEPROM])
    else $error("eeprom flag kept after service");
  touch_flag_clr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_TOUCH] && !events_in.touch_slot_overflow && !wr_flags |=> !flag_reg[`SRC_TOUCH])
    else $error("touch flag kept after service");
  serial_flag_clr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_SERIAL] && !wr_flags && !events_in.serial_byte_done && !events_in.serial_addr_match
      && !events_in.serial_timeout |=> !flag_reg[`SRC_SERIAL])
    else $error("serial flag kept after service");
  adc_flag_clr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_ADC] && !events_in.adc_done && !wr_flags |=> !flag_reg[`SRC_ADC])
    else $error("adc flag kept after service");
  eeprom_vec_addr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_EEPROM] |=> vector_out.vector_valid && vector_out.vector_addr == `VEC_EEPROM)
    else $error("wrong eeprom vector");
  touch_vec_addr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_TOUCH] |=> vector_out.vector_valid && vector_out.vector_addr == `VEC_TOUCH)
    else $error("wrong touch vector");
  serial_vec_addr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_SERIAL] |=> vector_out.vector_valid && vector_out.vector_addr == `VEC_SERIAL)
    else $error("wrong serial vector");
  adc_vec_addr_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      grant[`SRC_ADC] |=> vector_out.vector_valid && vector_out.vector_addr == `VEC_ADC)
    else $error("wrong adc vector");
  touch_first_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      take && eligible[`SRC_TOUCH] |-> grant[`SRC_TOUCH])
    else $error("touch request not served first");
  one_grant_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      $onehot0(grant))
    else $error("more than one source granted");
  vector_spacing_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      vector_out.vector_valid |=> !vector_out.vector_valid)
    else $error("back-to-back vectors");
  push_with_vector_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      push_pc_out == vector_out.vector_valid)
    else $error("push not paired with vector");
  plain_exit_keeps_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      plain_subroutine_exit_in && !irq_exit_instr_in && !wr_ctrl && !global_irq_enable_reg
      |=> !global_irq_enable_reg)
    else $error("plain exit enabled interrupts");
  wake_any_rise_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (flag_reg & ~$past(flag_reg)) != '0 |=> wakeup_out)
    else $error("flag rise without wake-up");

  cover_vector_c: cover property (@(posedge mclk_in) disable iff (rst_in) take ##1 push_pc_out);
  cover_two_pending_c: cover property (@(posedge mclk_in) disable iff (rst_in) take && $countones(eligible) > 1);
  cover_wake_c: cover property (@(posedge mclk_in) disable iff (rst_in) wakeup_out);
  cover_full_c: cover property (@(posedge mclk_in) disable iff (rst_in) stack_full && |eligible);
  cover_exit_c: cover property (@(posedge mclk_in) disable iff (rst_in) irq_exit_instr_in ##1 global_irq_enable_reg);
endmodule

//--- bench/core_seq_model.sv
// core sequencer stand-in: stack level and return pulses
// assumes push pulses from the interrupt logic and one-cycle return commands
module core_seq_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic push_pc_in,
  input wire logic [1:0] exit_kind_in,
  input wire logic load_en_in,
  input wire logic [3:0] load_level_in,
  output logic [3:0] stack_level_out,
  output logic irq_exit_out,
  output logic plain_exit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // kind 1 is the interrupt return, kind 2 the plain one; a routine never calls
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_exit_out <= 1'b0;
      plain_exit_out <= 1'b0;
    end else begin
      irq_exit_out <= (exit_kind_in == 2'h1);
      plain_exit_out <= (exit_kind_in == 2'h2);
    end
  end
  // only the return address is stacked; load fakes a full stack
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stack_level_out <= 4'h0;
    end else if (load_en_in) begin
      stack_level_out <= load_level_in;
    end else if (push_pc_in) begin
      stack_level_out <= stack_level_out + 4'h1;
    end else if ((irq_exit_out || plain_exit_out) && stack_level_out != 4'h0) begin
      stack_level_out <= stack_level_out - 4'h1;
    end
  end
endmodule

//--- bench/peripheral_interrupt_logic_tb.sv
// self-checking bench for the peripheral interrupt logic
// assumes the sequencer model and the cfg header on the include path
`include "peripheral_irq_cfg.svh"
module peripheral_interrupt_logic_tb;
  import peripheral_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] ev; logic [7:0] ctrl; logic [7:0] flag; logic [11:0] vec;} row_type;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  periph_events_type ev = '0;
  reg_req_type bus = '0;
  logic [1:0] exit_kind = 2'h0;
  logic load_en = 1'b0;
  logic [3:0] load_level = 4'h0;
  logic [3:0] stack_level;
  logic irq_exit, plain_exit, push_pc, wakeup;
  logic [7:0] rdata;
  vector_out_type vec;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_vec = 0;
  int n_wake = 0;
  int cyc = 0;
  logic [11:0] last_vec = 12'h000;
  row_type rows [6] = '{'{8'h80, 8'h01, 8'h01, `VEC_EEPROM}, '{8'h40, 8'h02, 8'h02, `VEC_TOUCH},
    '{8'h08, 8'h04, 8'h04, `VEC_SERIAL}, '{8'h04, 8'h04, 8'h04, `VEC_SERIAL},
    '{8'h02, 8'h04, 8'h04, `VEC_SERIAL}, '{8'h01, 8'h08, 8'h08, `VEC_ADC}};
  logic [11:0] prio [4] = '{`VEC_TOUCH, `VEC_SERIAL, `VEC_EEPROM, `VEC_ADC};
  always #20 mclk_in = ~mclk_in;
  peripheral_interrupt_logic #(.STACK_DEPTH(8)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .events_in(ev),
    .bus_in(bus), .stack_level_in(stack_level), .irq_exit_instr_in(irq_exit),
    .plain_subroutine_exit_in(plain_exit), .rdata_out(rdata), .vector_out(vec), .push_pc_out(push_pc),
    .wakeup_out(wakeup));
  core_seq_model i_core (.mclk_in(mclk_in), .rst_in(rst_in), .push_pc_in(push_pc), .exit_kind_in(exit_kind),
    .load_en_in(load_en), .load_level_in(load_level), .stack_level_out(stack_level), .irq_exit_out(irq_exit),
    .plain_exit_out(plain_exit));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  // outputs are sampled mid-cycle so they never race the launching edge
  always @(negedge mclk_in) begin
    cyc++;
    if (vec.vector_valid === 1'b1) begin
      n_vec++;
      last_vec = vec.vector_addr;
    end
    if (wakeup === 1'b1) n_wake++;
    if (cyc == 4000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_in);
    bus <= '0;
    @(negedge mclk_in);
    chk(rdata === e, "read data");
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge mclk_in);
    ev <= e;
    @(posedge mclk_in);
    ev <= '0;
  endtask
  task automatic do_exit(input logic [1:0] k);
    @(posedge mclk_in);
    exit_kind <= k;
    @(posedge mclk_in);
    exit_kind <= 2'h0;
  endtask
  task automatic load(input logic [3:0] l);
    @(posedge mclk_in);
    load_en <= 1'b1;
    load_level <= l;
    @(posedge mclk_in);
    load_en <= 1'b0;
  endtask
  task automatic wait_vec(input int n0, input logic [11:0] a);
    for (int k = 0; k < 10 && n_vec == n0; k++) @(posedge mclk_in);
    @(negedge mclk_in);
    chk(n_vec == n0 + 1 && last_vec === a, "vector address");
  endtask
  initial begin
    int n0;
    int w0;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(`ADDR_CTRL, 8'h00);
    rd(`ADDR_FLAGS, 8'h00);
    foreach (rows[i]) begin
      n0 = n_vec;
      w0 = n_wake;
      wr(`ADDR_CTRL, rows[i].ctrl);
      pulse(rows[i].ev);
      repeat (3) @(posedge mclk_in);
      chk(n_vec == n0, "vector taken while globally disabled");
      chk(n_wake == w0 + 1, "wake-up count");
      rd(`ADDR_FLAGS, rows[i].flag);
      wr(`ADDR_CTRL, rows[i].ctrl | 8'h10);
      wait_vec(n0, rows[i].vec);
      rd(`ADDR_FLAGS, 8'h00);
      rd(`ADDR_STACK, 8'h01);
      do_exit(2'h2);
      rd(`ADDR_CTRL, rows[i].ctrl);
    end
    // all four pending at once, released one by one by interrupt returns
    wr(`ADDR_CTRL, 8'h0f);
    wr(`ADDR_FLAGS, 8'h0f);
    for (int j = 0; j < 4; j++) begin
      n0 = n_vec;
      do_exit(2'h1);
      wait_vec(n0, prio[j]);
    end
    do_exit(2'h2);
    load(4'h8);
    n0 = n_vec;
    wr(`ADDR_CTRL, 8'h11);
    pulse(8'h80);
    repeat (4) @(posedge mclk_in);
    chk(n_vec == n0, "vector with full stack");
    rd(`ADDR_STACK, 8'h08);
    load(4'h0);
    wait_vec(n0, `VEC_EEPROM);
    do_exit(2'h2);
    wr(`ADDR_CTRL, 8'h00);
    pulse(8'h30);
    repeat (5) @(posedge mclk_in);
    rd(`ADDR_FLAGS, 8'h30);
    wr(`ADDR_FLAGS, 8'h00);
    rd(`ADDR_FLAGS, 8'h00);
    w0 = n_wake;
    wr(`ADDR_FLAGS, 8'h08);
    repeat (3) @(posedge mclk_in);
    chk(n_wake == w0 + 1, "no wake-up from software set with enables off");
    w0 = n_wake;
    pulse(8'h01);
    repeat (3) @(posedge mclk_in);
    chk(n_wake == w0, "wake-up from preset flag");
    rd(`ADDR_FLAGS, 8'h08);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    rd(`ADDR_CTRL, 8'h00);
    // reset in mid-run must drop enables, request flags and sticky flags
    wr(`ADDR_CTRL, 8'h17);
    rd(`ADDR_CTRL, 8'h17);
    pulse(8'h30);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(`ADDR_CTRL, 8'h00);
    rd(`ADDR_FLAGS, 8'h00);
    rd(`ADDR_STACK, 8'h00);
    wrap_up();
  end
endmodule
